/* fbs_pkg.sv */
// Purpose: Shared constants and types for the fieldbus I/O connection scheduler.
// Assumes: 50 MHz system clock, 32-bit classic Wishbone register port.
// Notes:   Every offset, field position, reset value and timing count lives here.

package fbs_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 20;
	localparam int unsigned MS_NS            = 1000000;
	localparam int unsigned CYC_PER_MS_DFLT  = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned RSP_TIMEOUT_MS   = 2;
	localparam logic [3:0]  TMO_LAST         = 4'(RSP_TIMEOUT_MS - 1);

	// Table geometry: one entry per node address and slot
	localparam int unsigned NODE_W = 6;
	localparam int unsigned N_NODE = 64;
	localparam int unsigned ENT_W  = 7;
	localparam int unsigned N_ENT  = 128;
	localparam logic [7:0]  STROBE_LEN = 8'h01;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
	localparam logic [7:0] REG_CFG_SEL  = 8'h10;
	localparam logic [7:0] REG_CFG_TYPE = 8'h14;
	localparam logic [7:0] REG_CFG_LEN  = 8'h18;
	localparam logic [7:0] REG_CFG_UPD  = 8'h1c;
	localparam logic [7:0] REG_SCAN_IV  = 8'h20;
	localparam logic [7:0] REG_FAIL_LO  = 8'h24;
	localparam logic [7:0] REG_FAIL_HI  = 8'h28;
	localparam logic [7:0] REG_LAST_RSP = 8'h2c;

	// Field positions
	localparam int unsigned CTRL_RUN_BIT  = 0;
	localparam int unsigned ST_BUSY_BIT   = 0;
	localparam int unsigned ST_ROUND_BIT  = 1;
	localparam int unsigned ST_IDX_LSB    = 8;
	localparam int unsigned SEL_SLOT_BIT  = 8;
	localparam int unsigned LEN_OUT_LSB   = 8;
	localparam int unsigned LAST_LEN_LSB  = 8;
	localparam int unsigned IRQ_DONE      = 0;
	localparam int unsigned IRQ_LEN       = 1;
	localparam int unsigned IRQ_CFG       = 2;
	localparam int unsigned IRQ_TMO       = 3;
	localparam int unsigned IRQ_W         = 4;

	// Reset values
	localparam logic             CTRL_RST    = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam logic [15:0]      SCAN_IV_RST = 16'h0000;

	// Connection types
	typedef enum logic [2:0] {
		CT_DISABLED = 3'h0,
		CT_POLLED   = 3'h1,
		CT_STROBED  = 3'h2,
		CT_COS      = 3'h3,
		CT_CYCLIC   = 3'h4
	} fbs_ctype_t;

	// Outgoing message kinds
	typedef enum logic [1:0] {
		MK_POLL   = 2'h0,
		MK_STROBE = 2'h1,
		MK_COS    = 2'h2,
		MK_CYCLIC = 2'h3
	} fbs_msg_t;

	// Scheduler states, Gray along idle-walk-send-wait
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WALK = 2'b01,
		S_SEND = 2'b11,
		S_WAIT = 2'b10
	} fbs_state_t;

endpackage

/* fbs_ms_tick.sv */
// Purpose: Millisecond enable pulse from the system clock.
// Assumes: Single clock domain, synchronous reset.
// Notes:   Count is a parameter so simulation can shorten it.

`timescale 1ns/1ps
`default_nettype none

module fbs_ms_tick #(
	parameter int unsigned CYC_PER_MS = fbs_pkg::CYC_PER_MS_DFLT
) (
	// System
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Pulse out
	output logic      tick_o
);
	import fbs_pkg::*;

	localparam logic [31:0] LAST = 32'(CYC_PER_MS - 1);

	logic [31:0] cnt_q;

	// Free-running divider; one-cycle pulse per wrap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q  <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 32'h1;
			tick_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* fbs_pair_check.sv */
// Purpose: Decide whether a connection type may sit beside the other slot's type.
// Assumes: Purely combinational.
// Notes:   Unknown encodings are refused as well.

`timescale 1ns/1ps
`default_nettype none

module fbs_pair_check (
	// Types
	input  wire logic [2:0] new_type_i,
	input  wire logic [2:0] other_type_i,
	// Verdict
	output logic            ok_o
);
	import fbs_pkg::*;

	logic new_per;
	logic oth_per;
	logic known;

	// Change-of-state and cyclic form one exclusive group
	assign new_per = (new_type_i == CT_COS) || (new_type_i == CT_CYCLIC);
	assign oth_per = (other_type_i == CT_COS) || (other_type_i == CT_CYCLIC);
	assign known   = (new_type_i <= CT_CYCLIC);

	// Disabled always fits; duplicates of polled or strobed do not
	always_comb begin
		ok_o = known;
		if ((new_type_i == CT_POLLED) && (other_type_i == CT_POLLED)) begin
			ok_o = 1'b0;
		end
		if ((new_type_i == CT_STROBED) && (other_type_i == CT_STROBED)) begin
			ok_o = 1'b0;
		end
		if (new_per && oth_per) begin
			ok_o = 1'b0;
		end
	end

endmodule

`default_nettype wire

/* fbs_scheduler.sv */
// Purpose: Master-side cyclic I/O scheduler for up to 64 fieldbus slaves.
// Assumes: 50 MHz clk_i, synchronous active-high reset, classic Wishbone slave.
// Notes:   Message framing and the wire itself belong to a separate link layer.

`timescale 1ns/1ps
`default_nettype none

module fbs_scheduler #(
	parameter int unsigned CYC_PER_MS = fbs_pkg::CYC_PER_MS_DFLT
) (
	// System
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [7:0]                 wb_adr_i,
	input  wire logic [31:0]                wb_dat_i,
	input  wire logic [3:0]                 wb_sel_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// Interrupt
	output logic                            irq_o,
	// Outgoing message request
	output logic                            tx_valid_o,
	input  wire logic                       tx_ready_i,
	output var fbs_pkg::fbs_msg_t           tx_kind_o,
	output logic      [fbs_pkg::NODE_W-1:0] tx_node_o,
	output logic      [7:0]                 tx_len_o,
	// Incoming response
	input  wire logic                       rx_valid_i,
	input  wire logic [fbs_pkg::NODE_W-1:0] rx_node_i,
	input  wire logic [7:0]                 rx_len_i,
	input  wire logic                       rx_err_i,
	// Change-of-state report from a slave
	input  wire logic                       cos_valid_i,
	input  wire logic [fbs_pkg::NODE_W-1:0] cos_node_i
);
	import fbs_pkg::*;

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] m;
		m = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		return m;
	endfunction

	// One-hot flag for a node address
	function automatic logic [N_NODE-1:0] node_bit(input logic [NODE_W-1:0] n);
		return 64'h1 << n;
	endfunction

	// Connection table, indexed {node, slot}
	fbs_ctype_t  type_q    [N_ENT];
	logic [7:0]  in_len_q  [N_ENT];
	logic [7:0]  out_len_q [N_ENT];
	logic [15:0] upd_q     [N_ENT];
	logic [15:0] stamp_q   [N_ENT];

	// Bus and register state
	logic              ack_q;
	logic              acc;
	logic              wr;
	logic [31:0]       rd_cur;
	logic [31:0]       wdat;
	logic [31:0]       clr;
	logic              ctrl_run_q;
	logic [IRQ_W-1:0]  irq_stat_q;
	logic [IRQ_W-1:0]  irq_mask_q;
	logic [IRQ_W-1:0]  ev;
	logic [NODE_W-1:0] sel_node_q;
	logic              sel_slot_q;
	logic [7:0]        stg_in_q;
	logic [7:0]        stg_out_q;
	logic [15:0]       stg_upd_q;
	logic [15:0]       scan_iv_q;
	logic [N_NODE-1:0] fail_q;
	logic [NODE_W-1:0] last_node_q;
	logic [7:0]        last_len_q;
	logic [ENT_W-1:0]  sel_idx;
	logic [ENT_W-1:0]  oth_idx;
	logic              pair_ok;
	logic              cfg_wr;

	// Scheduler state
	fbs_state_t        state_q;
	logic [ENT_W-1:0]  idx_q;
	logic              round_q;
	logic              bcast_q;
	logic [3:0]        tmo_q;
	logic [15:0]       now_ms_q;
	logic [15:0]       scan_cnt_q;
	logic              strobe_flag_q;
	logic [N_NODE-1:0] cos_pend_q;
	logic              ms_tick;
	logic              strobe_due;
	logic [NODE_W-1:0] cur_node;
	fbs_ctype_t        cur_type;
	logic [15:0]       age;
	logic              due;
	logic              node_ok;
	logic              do_send;
	logic              do_wait;
	logic              last;
	logic              rsp_hit;
	logic              tmo_done;
	logic              len_bad;
	fbs_msg_t          kind_d;

	fbs_ms_tick #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_tick (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (ms_tick)
	);

	// Proposed type checked against the partner slot of the same node
	assign sel_idx = {sel_node_q, sel_slot_q};
	assign oth_idx = {sel_node_q, ~sel_slot_q};

	fbs_pair_check u_pair (
		.new_type_i   (wdat[2:0]),
		.other_type_i (type_q[oth_idx]),
		.ok_o         (pair_ok)
	);

	// Bus access: answered one cycle after the request is seen
	assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr       = acc & wb_we_i;
	assign wdat     = be_merge(rd_cur, wb_dat_i, wb_sel_i);
	assign clr      = be_merge(32'h0, wb_dat_i, wb_sel_i);
	assign cfg_wr   = wr && (wb_adr_i == REG_CFG_TYPE);
	assign wb_ack_o = ack_q;
	assign irq_o    = |(irq_stat_q & irq_mask_q);

	// Read view of the addressed register; unmapped reads as zero
	always_comb begin
		rd_cur = 32'h0;
		case (wb_adr_i)
			REG_CTRL:     rd_cur[CTRL_RUN_BIT] = ctrl_run_q;
			REG_STATUS: begin
				rd_cur[ST_BUSY_BIT]            = (state_q != S_IDLE);
				rd_cur[ST_ROUND_BIT]           = round_q;
				rd_cur[ST_IDX_LSB +: ENT_W]    = idx_q;
			end
			REG_IRQ_STAT: rd_cur[IRQ_W-1:0]    = irq_stat_q;
			REG_IRQ_MASK: rd_cur[IRQ_W-1:0]    = irq_mask_q;
			REG_CFG_SEL: begin
				rd_cur[NODE_W-1:0]             = sel_node_q;
				rd_cur[SEL_SLOT_BIT]           = sel_slot_q;
			end
			REG_CFG_TYPE: rd_cur[2:0]          = type_q[sel_idx];
			REG_CFG_LEN: begin
				rd_cur[7:0]                    = in_len_q[sel_idx];
				rd_cur[LEN_OUT_LSB +: 8]       = out_len_q[sel_idx];
			end
			REG_CFG_UPD:  rd_cur[15:0]         = upd_q[sel_idx];
			REG_SCAN_IV:  rd_cur[15:0]         = scan_iv_q;
			REG_FAIL_LO:  rd_cur               = fail_q[31:0];
			REG_FAIL_HI:  rd_cur               = fail_q[63:32];
			REG_LAST_RSP: begin
				rd_cur[NODE_W-1:0]             = last_node_q;
				rd_cur[LAST_LEN_LSB +: 8]      = last_len_q;
			end
			default:      rd_cur               = 32'h0;
		endcase
	end

	// Bus handshake and registered read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ack_q <= acc;
			if (acc) begin
				wb_dat_o <= wb_we_i ? 32'h0 : rd_cur;
			end
		end
	end

	// Plain software registers; staged values wait for the type commit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_run_q <= CTRL_RST;
			irq_mask_q <= IRQ_MASK_RST;
			sel_node_q <= '0;
			sel_slot_q <= 1'b0;
			stg_in_q   <= 8'h00;
			stg_out_q  <= 8'h00;
			stg_upd_q  <= 16'h0000;
			scan_iv_q  <= SCAN_IV_RST;
		end else if (wr) begin
			case (wb_adr_i)
				REG_CTRL:     ctrl_run_q <= wdat[CTRL_RUN_BIT];
				REG_IRQ_MASK: irq_mask_q <= wdat[IRQ_W-1:0];
				REG_CFG_SEL: begin
					sel_node_q <= wdat[NODE_W-1:0];
					sel_slot_q <= wdat[SEL_SLOT_BIT];
				end
				REG_CFG_LEN: begin
					stg_in_q  <= wdat[7:0];
					stg_out_q <= wdat[LEN_OUT_LSB +: 8];
				end
				REG_CFG_UPD:  stg_upd_q  <= wdat[15:0];
				REG_SCAN_IV:  scan_iv_q  <= wdat[15:0];
				default:      ctrl_run_q <= ctrl_run_q;
			endcase
		end
	end

	// Table commit; illegal pairings leave the entry untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < N_ENT; i++) begin
				type_q[i]    <= CT_DISABLED;
				in_len_q[i]  <= 8'h00;
				out_len_q[i] <= 8'h00;
				upd_q[i]     <= 16'h0000;
			end
		end else if (cfg_wr && pair_ok) begin
			type_q[sel_idx]    <= fbs_ctype_t'(wdat[2:0]);
			in_len_q[sel_idx]  <= stg_in_q;
			out_len_q[sel_idx] <= stg_out_q;
			upd_q[sel_idx]     <= stg_upd_q;
		end
	end

	// Event flags: a new event beats a simultaneous write-one clear
	assign ev[IRQ_CFG] = cfg_wr & ~pair_ok;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr && wb_adr_i == REG_IRQ_STAT) ?
				clr[IRQ_W-1:0] : 4'h0)) | ev;
		end
	end

	// Current entry and what it needs this pass
	assign cur_node = idx_q[ENT_W-1:1];
	assign cur_type = type_q[idx_q];
	assign age      = now_ms_q - stamp_q[idx_q];
	assign due      = (upd_q[idx_q] == 16'h0000) || (age >= upd_q[idx_q]);
	assign node_ok  = ~fail_q[cur_node];
	assign last     = &idx_q;
	assign strobe_due = (scan_iv_q == 16'h0000) | strobe_flag_q;

	always_comb begin
		do_send = 1'b0;
		do_wait = 1'b0;
		kind_d  = MK_POLL;
		case (cur_type)
			CT_POLLED: begin
				do_send = due & node_ok;
			end
			CT_CYCLIC: begin
				do_send = due & node_ok;
				kind_d  = MK_CYCLIC;
			end
			CT_COS: begin
				do_send = cos_pend_q[cur_node] & node_ok;
				kind_d  = MK_COS;
			end
			CT_STROBED: do_wait = round_q & node_ok;
			default:    do_send = 1'b0;
		endcase
	end

	// Response checking against the table
	assign rsp_hit  = (state_q == S_WAIT) && rx_valid_i && (rx_node_i == cur_node);
	assign len_bad  = (rx_len_i != in_len_q[idx_q]) | rx_err_i;
	assign tmo_done = (state_q == S_WAIT) && !rsp_hit && ms_tick && (tmo_q == TMO_LAST);
	assign ev[IRQ_LEN]  = rsp_hit & len_bad;
	assign ev[IRQ_TMO]  = tmo_done;
	assign ev[IRQ_DONE] = last && (((state_q == S_WALK) && !do_send && !do_wait) ||
		rsp_hit || tmo_done);
	assign tx_valid_o = (state_q == S_SEND);

	// Walk the table in ascending address order, no idle between exchanges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= S_IDLE;
			idx_q     <= '0;
			round_q   <= 1'b0;
			bcast_q   <= 1'b0;
			tmo_q     <= 4'h0;
			tx_kind_o <= MK_POLL;
			tx_node_o <= '0;
			tx_len_o  <= 8'h00;
		end else begin
			case (state_q)
				S_IDLE: if (ctrl_run_q) begin
					idx_q   <= '0;
					round_q <= strobe_due;
					bcast_q <= strobe_due;
					if (strobe_due) begin
						tx_kind_o <= MK_STROBE;
						tx_node_o <= '0;
						tx_len_o  <= STROBE_LEN;
						state_q   <= S_SEND;
					end else begin
						state_q <= S_WALK;
					end
				end
				S_WALK: if (do_send) begin
					tx_kind_o <= kind_d;
					tx_node_o <= cur_node;
					tx_len_o  <= out_len_q[idx_q];
					state_q   <= S_SEND;
				end else if (do_wait) begin
					tmo_q   <= 4'h0;
					state_q <= S_WAIT;
				end else if (last) begin
					state_q <= S_IDLE;
				end else begin
					idx_q <= idx_q + 7'h01;
				end
				S_SEND: if (tx_ready_i) begin
					bcast_q <= 1'b0;
					tmo_q   <= 4'h0;
					state_q <= bcast_q ? S_WALK : S_WAIT;
				end
				S_WAIT: if (rsp_hit || tmo_done) begin
					if (last) begin
						state_q <= S_IDLE;
					end else begin
						idx_q   <= idx_q + 7'h01;
						state_q <= S_WALK;
					end
				end else if (ms_tick) begin
					tmo_q <= tmo_q + 4'h1;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Time stamp of each connection's last dispatch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < N_ENT; i++) begin
				stamp_q[i] <= 16'h0000;
			end
		end else if ((state_q == S_WALK) && do_send) begin
			stamp_q[idx_q] <= now_ms_q;
		end
	end

	// Millisecond clock and strobe scan interval
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			now_ms_q      <= 16'h0000;
			scan_cnt_q    <= 16'h0000;
			strobe_flag_q <= 1'b0;
		end else begin
			if (ms_tick) begin
				now_ms_q <= now_ms_q + 16'h0001;
			end
			if (ms_tick && (scan_cnt_q + 16'h0001 >= scan_iv_q)) begin
				scan_cnt_q    <= 16'h0000;
				strobe_flag_q <= 1'b1;
			end else begin
				if (ms_tick) begin
					scan_cnt_q <= scan_cnt_q + 16'h0001;
				end
				if ((state_q == S_IDLE) && ctrl_run_q) begin
					strobe_flag_q <= 1'b0;
				end
			end
		end
	end

	// Pending change-of-state reports; a fresh report beats the service clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cos_pend_q <= '0;
		end else begin
			cos_pend_q <= (cos_pend_q & ~(((state_q == S_WALK) && do_send &&
				(cur_type == CT_COS)) ? node_bit(cur_node) : 64'h0)) |
				(cos_valid_i ? node_bit(cos_node_i) : 64'h0);
		end
	end

	// Failed nodes are skipped until software clears them; set wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fail_q <= '0;
		end else begin
			fail_q <= (fail_q & ~({(wr && wb_adr_i == REG_FAIL_HI) ? clr : 32'h0,
				(wr && wb_adr_i == REG_FAIL_LO) ? clr : 32'h0})) |
				(((rsp_hit && len_bad) || tmo_done) ? node_bit(cur_node) : 64'h0);
		end
	end

	// Last response seen, for software diagnosis
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_node_q <= '0;
			last_len_q  <= 8'h00;
		end else if (rsp_hit) begin
			last_node_q <= rx_node_i;
			last_len_q  <= rx_len_i;
		end
	end

endmodule

`default_nettype wire

/* fbs_sched_props.sv */
// Purpose: Port-level checker for the fieldbus I/O connection scheduler.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Sees only top-level ports; attached by bind at the foot.

`timescale 1ns/1ps
`default_nettype none

module fbs_sched_props (
	// System
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Register bus
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              irq_o,
	// Outgoing message
	input wire logic              tx_valid_o,
	input wire logic              tx_ready_i,
	input wire fbs_pkg::fbs_msg_t tx_kind_o,
	input wire logic [5:0]        tx_node_o,
	input wire logic [7:0]        tx_len_o
);
	import fbs_pkg::*;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A request that has not yet been answered
	sequence sq_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// A poll handed to the link layer
	sequence sq_poll_sent;
		tx_valid_o && tx_ready_i && tx_kind_o == MK_POLL;
	endsequence

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack lasted more than one cycle");
	a_ack_answer: assert property (sq_req |=> wb_ack_o)
		else $error("request not answered in one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	a_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
		else $error("read data moved without an access");
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable({tx_kind_o, tx_node_o, tx_len_o}))
		else $error("message changed before acceptance");
	a_strobe_form: assert property (tx_valid_o && tx_kind_o == MK_STROBE |->
		tx_len_o == STROBE_LEN && tx_node_o == 6'h00)
		else $error("strobe broadcast malformed");
	a_poll_wait: assert property (sq_poll_sent |=> !tx_valid_o [*2])
		else $error("new message before poll response");
	a_reset_quiet: assert property ($fell(rst_i) |-> !tx_valid_o && !wb_ack_o && !irq_o)
		else $error("outputs active right after reset");
endmodule

bind fbs_scheduler fbs_sched_props u_props (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
	.tx_kind_o(tx_kind_o), .tx_node_o(tx_node_o), .tx_len_o(tx_len_o));

`default_nettype wire

/* fbs_slave_model.sv */
// Purpose: Behavioural model of the slaves and link layer facing the scheduler.
// Assumes: One clock, synchronous reset; one message in flight.
// Notes:   Every slave answers with the same input count; slow adds delay.

`timescale 1ns/1ps
`default_nettype none

module fbs_slave_model (
	// System
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Test controls
	input  wire logic [7:0]        in_len_i,
	input  wire logic [7:0]        out_len_i,
	input  wire logic              slow_i,
	input  wire logic [63:0]       strobe_mask_i,
	// Message from the master
	input  wire logic              tx_valid_i,
	input  wire fbs_pkg::fbs_msg_t tx_kind_i,
	input  wire logic [5:0]        tx_node_i,
	input  wire logic [7:0]        tx_len_i,
	output logic                   tx_ready_o,
	// Response to the master
	output logic                   rx_valid_o,
	output logic [5:0]             rx_node_o,
	output logic [7:0]             rx_len_o,
	output logic                   rx_err_o
);
	import fbs_pkg::*;

	logic       pend_q;
	logic       strobe_q;
	logic       err_q;
	logic [5:0] node_q;
	logic [6:0] scan_q;
	logic [3:0] gap_q;

	// Accept, wait, then one reply, or one per masked node for a strobe; released lines toggle so stale values never match
	always_ff @(posedge clk_i) begin
		tx_ready_o <= 1'b0;
		rx_valid_o <= 1'b0;
		rx_node_o  <= ~rx_node_o;
		rx_len_o   <= ~rx_len_o;
		rx_err_o   <= ~rx_err_o;
		if (rst_i) begin
			pend_q    <= 1'b0;
			gap_q     <= 4'h0;
			rx_node_o <= 6'h00;
			rx_len_o  <= 8'h00;
			rx_err_o  <= 1'b0;
		end else if (gap_q != 4'h0) begin
			gap_q <= gap_q - 4'h1;
		end else if (pend_q && strobe_q) begin
			scan_q <= scan_q + 7'h01;
			if (scan_q[6]) begin
				pend_q <= 1'b0;
			end else if (strobe_mask_i[scan_q[5:0]]) begin
				rx_valid_o <= 1'b1;
				rx_node_o  <= scan_q[5:0];
				rx_len_o   <= in_len_i;
				rx_err_o   <= 1'b0;
				gap_q      <= 4'h3; // Spacing lets the master step to its next entry
			end else begin
				gap_q <= 4'h1; // Two cycles a node, the pace of the master's walk
			end
		end else if (pend_q) begin
			rx_valid_o <= 1'b1;
			rx_node_o  <= node_q;
			rx_len_o   <= in_len_i;
			rx_err_o   <= err_q;
			pend_q     <= 1'b0;
		end else if (tx_valid_i && !tx_ready_o) begin
			tx_ready_o <= 1'b1;
			pend_q     <= 1'b1;
			strobe_q   <= tx_kind_i == MK_STROBE;
			node_q     <= tx_node_i;
			err_q      <= tx_len_i != out_len_i;
			scan_q     <= 7'h00;
			// A strobe reply must not land before the master parks on that entry
			gap_q      <= (tx_kind_i == MK_STROBE) ? 4'hf : (slow_i ? 4'h8 : 4'h1);
		end
	end
endmodule

`default_nettype wire

/* test_fbs_scheduler.sv */
// Purpose: Self-checking bench for the fieldbus I/O connection scheduler.
// Assumes: Millisecond count shortened to 20 cycles.
// Notes:   Walks are started, waited on through the done interrupt, then stopped.

`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end

module test_fbs_scheduler;
	import fbs_pkg::*;

	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              wb_cyc, wb_stb, wb_we, wb_ack, irq, cos_valid, slow;
	logic              tx_valid, tx_ready, rx_valid, rx_err;
	logic [7:0]        wb_adr, tx_len, rx_len, in_len, out_len;
	logic [31:0]       wb_wdat, wb_rdat, rv;
	logic [3:0]        wb_sel;
	logic [5:0]        tx_node, rx_node, cos_node;
	logic [63:0]       smask;
	fbs_msg_t          tx_kind;
	logic [15:0]       txq[$];
	int                bad_count = 0;
	int                tests_run = 0;
	int                n_data = 0;

	always #10 clk_i = ~clk_i;

	fbs_scheduler #(.CYC_PER_MS(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
		.wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
		.tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_kind_o(tx_kind), .tx_node_o(tx_node),
		.tx_len_o(tx_len), .rx_valid_i(rx_valid), .rx_node_i(rx_node), .rx_len_i(rx_len),
		.rx_err_i(rx_err), .cos_valid_i(cos_valid), .cos_node_i(cos_node));

	fbs_slave_model u_slaves (.clk_i(clk_i), .rst_i(rst_i), .in_len_i(in_len),
		.out_len_i(out_len), .slow_i(slow), .strobe_mask_i(smask), .tx_valid_i(tx_valid),
		.tx_kind_i(tx_kind), .tx_node_i(tx_node), .tx_len_i(tx_len), .tx_ready_o(tx_ready),
		.rx_valid_o(rx_valid), .rx_node_o(rx_node), .rx_len_o(rx_len), .rx_err_o(rx_err));

	// Log every message the link layer accepts; data messages are counted apart from strobes
	always @(posedge clk_i) if (tx_valid && tx_ready) begin
		txq.push_back({tx_kind, tx_node, tx_len});
		if (tx_kind != MK_STROBE) n_data++;
	end

	// Legal pairing of the two slots of one slave, worked out independently
	function automatic logic ok(int a, int b);
		return b < 5 && !(a == b && (a == 1 || a == 2)) && !(a > 2 && b > 2);
	endfunction

	// One classic bus cycle; read data lands in rv
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_wdat <= d;
		do begin @(posedge clk_i); n++; end while (wb_ack !== 1'b1 && n < 20);
		if (n == 20) bad_count++;
		rv = wb_rdat;
		wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
	endtask

	task automatic cfg(input logic [5:0] n, input logic s, input int t, input logic [15:0] l);
		wb(REG_CFG_SEL, 1'b1, {23'h0, s, 2'h0, n});
		wb(REG_CFG_LEN, 1'b1, {16'h0, l});
		wb(REG_CFG_UPD, 1'b1, 32'h0);
		wb(REG_CFG_TYPE, 1'b1, 32'(t));
	endtask

	// Run one walk to its done interrupt, then stop and wait for idle
	task automatic walk;
		int n;
		n = 0;
		txq.delete();
		n_data = 0;
		wb(REG_IRQ_STAT, 1'b1, 32'hf);
		wb(REG_CTRL, 1'b1, 32'h1);
		while (irq !== 1'b1 && n < 3000) begin @(posedge clk_i); n++; end
		if (n == 3000) bad_count++;
		wb(REG_CTRL, 1'b1, 32'h0);
		rv = 32'h1;
		for (n = 0; n < 300 && rv[ST_BUSY_BIT] !== 1'b0; n++) wb(REG_STATUS, 1'b0, 32'h0);
		if (rv[ST_BUSY_BIT] !== 1'b0) bad_count++;
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#1000000;
		bad_count++;
		close_out();
	end

	initial begin
		wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 0; wb_wdat = 0; wb_sel = 4'hf;
		cos_valid = 0; cos_node = 0; in_len = 8'h04; out_len = 8'h02; slow = 0; smask = 64'h4;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values and an unmapped address
		wb(REG_CTRL, 1'b0, 32'h0); `CHK(rv[CTRL_RUN_BIT], CTRL_RST)
		wb(REG_IRQ_MASK, 1'b0, 32'h0); `CHK(rv[3:0], IRQ_MASK_RST)
		wb(REG_SCAN_IV, 1'b0, 32'h0); `CHK(rv[15:0], SCAN_IV_RST)
		wb(REG_CFG_SEL, 1'b1, 32'h13f);
		wb(REG_CFG_TYPE, 1'b0, 32'h0); `CHK(rv[2:0], 3'h0)
		wb(8'h40, 1'b1, 32'hffff);
		wb(8'h40, 1'b0, 32'h0); `CHK(rv, 32'h0)
		// Every type beside every type, plus one unknown code
		for (int a = 0; a < 5; a++) for (int b = 0; b < 6; b++) begin
			cfg(6'd20, 1'b1, 0, 16'h0);
			cfg(6'd20, 1'b0, a, 16'h0);
			wb(REG_IRQ_STAT, 1'b1, 32'hf);
			cfg(6'd20, 1'b1, b, 16'h0);
			wb(REG_CFG_TYPE, 1'b0, 32'h0); `CHK(rv[2:0], ok(a, b) ? 3'(b) : 3'h0)
			wb(REG_IRQ_STAT, 1'b0, 32'h0); `CHK(rv[IRQ_CFG], ~ok(a, b))
		end
		cfg(6'd20, 1'b0, 0, 16'h0);
		// Strobe round, then two polls in ascending order
		cfg(6'd2, 1'b0, CT_STROBED, 16'h0104);
		cfg(6'd5, 1'b0, CT_POLLED, 16'h0204);
		cfg(6'd9, 1'b1, CT_POLLED, 16'h0204);
		wb(REG_IRQ_MASK, 1'b1, 32'h1);
		walk();
		`CHK(txq[0], {MK_STROBE, 6'h00, STROBE_LEN})
		`CHK(txq[1], {MK_POLL, 6'd5, 8'h02})
		`CHK(txq[2], {MK_POLL, 6'd9, 8'h02})
		// Interrupt level follows status and mask
		`CHK(irq, 1'b1)
		wb(REG_IRQ_MASK, 1'b1, 32'h0); `CHK(irq, 1'b0)
		wb(REG_IRQ_MASK, 1'b1, 32'h1); `CHK(irq, 1'b1)
		wb(REG_IRQ_STAT, 1'b1, 32'h1); `CHK(irq, 1'b0)
		wb(REG_LAST_RSP, 1'b0, 32'h0); `CHK(rv[15:0], 16'h0409)
		// Wrong input count on node 5, refused output count on node 9, slow slaves
		cfg(6'd2, 1'b0, CT_DISABLED, 16'h0);
		cfg(6'd5, 1'b0, CT_POLLED, 16'h0203);
		cfg(6'd9, 1'b1, CT_POLLED, 16'h0304);
		slow <= 1'b1;
		walk();
		wb(REG_FAIL_LO, 1'b0, 32'h0); `CHK(rv, 32'h220)
		wb(REG_IRQ_STAT, 1'b0, 32'h0); `CHK(rv[IRQ_LEN], 1'b1)
		// Failed nodes skipped; change-of-state idle until reported
		cfg(6'd7, 1'b1, CT_COS, 16'h0204);
		walk(); `CHK(n_data, 0)
		cos_node <= 6'd7;
		cos_valid <= 1'b1;
		@(posedge clk_i);
		cos_valid <= 1'b0;
		walk();
		`CHK(n_data, 1)
		`CHK(txq[1], {MK_COS, 6'd7, 8'h02})
		wb(REG_FAIL_LO, 1'b1, 32'h220);
		wb(REG_FAIL_LO, 1'b0, 32'h0); `CHK(rv, 32'h0)
		close_out();
	end
endmodule

`default_nettype wire
